//--- src/tmr_clk_sel.sv
// clock source selection: prescaler taps and external count input
`timescale 1ns/1ps
`default_nettype none

module tmr_clk_sel #(
  parameter int unsigned PRESC_W = tmr_pkg::PRESC_W
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] clock_source_select,
  input  wire logic       external_count_input,
  output var  logic       timer_tick
);

  // ==========================================================
  // parameter check
  if (PRESC_W < 10)
  begin : g_bad_width
    $error("prescaler must be at least 10 bits");
  end

  // ==========================================================
  // prescaler and input synchroniser
  logic [PRESC_W-1:0] presc_ff;
  logic               ext_meta_ff;
  logic               ext_sync_ff;
  logic               ext_prev_ff;
  logic               tick_ff;
  logic               nxt_tick;

  wire logic rise_ev = ext_sync_ff & ~ext_prev_ff;
  wire logic fall_ev = ~ext_sync_ff & ext_prev_ff;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      presc_ff    <= '0;
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
    end
    else
    begin
      presc_ff    <= presc_ff + 1'b1;
      ext_meta_ff <= external_count_input;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= ext_sync_ff;
    end
  end

  always_comb
  begin
    unique case (clock_source_select)
      tmr_pkg::CS_STOP:     nxt_tick = 1'b0;
      tmr_pkg::CS_DIV1:     nxt_tick = 1'b1;
      tmr_pkg::CS_DIV8:     nxt_tick = &presc_ff[2:0];
      tmr_pkg::CS_DIV64:    nxt_tick = &presc_ff[5:0];
      tmr_pkg::CS_DIV256:   nxt_tick = &presc_ff[7:0];
      tmr_pkg::CS_DIV1024:  nxt_tick = &presc_ff[9:0];
      tmr_pkg::CS_EXT_FALL: nxt_tick = fall_ev;
      tmr_pkg::CS_EXT_RISE: nxt_tick = rise_ev;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      tick_ff <= 1'b0;
    else
      tick_ff <= nxt_tick;
  end

  assign timer_tick = tick_ff;

endmodule : tmr_clk_sel

`default_nettype wire

//--- src/tmr_pkg.sv
// shared constants of the 8-bit timer with one compare channel
package tmr_pkg;

  // ==========================================================
  // register map
  localparam int unsigned ADDR_W = 3;
  localparam logic [2:0] REG_CTRL    = 3'h0;
  localparam logic [2:0] REG_CLKSEL  = 3'h1;
  localparam logic [2:0] REG_COUNT   = 3'h2;
  localparam logic [2:0] REG_COMPARE = 3'h3;
  localparam logic [2:0] REG_FLAG    = 3'h4;
  localparam logic [2:0] REG_MASK    = 3'h5;

  // ==========================================================
  // field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_COM_LSB  = 4;
  localparam int unsigned CTRL_FORCE    = 7;
  localparam int unsigned FLAG_OVF      = 0;
  localparam int unsigned FLAG_CMP      = 1;

  // ==========================================================
  // reset values
  localparam logic [1:0] MODE_RST  = 2'h0;
  localparam logic [1:0] COM_RST   = 2'h0;
  localparam logic [2:0] CS_RST    = 3'h0;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST   = 8'h00;

  // ==========================================================
  // count limits
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;

  // ==========================================================
  // operating modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE  = 2'h1;
  localparam logic [1:0] MODE_CTC    = 2'h2;
  localparam logic [1:0] MODE_FAST   = 2'h3;

  // ==========================================================
  // compare output actions
  localparam logic [1:0] COM_NONE   = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // ==========================================================
  // clock source select codes
  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_DIV1    = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int unsigned PRESC_W = 10;

endpackage : tmr_pkg

//--- src/tmr_timer8.sv
// 8-bit timer/counter with one compare channel and register port
`timescale 1ns/1ps
`default_nettype none

module tmr_timer8 (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output var  logic [7:0] rd_data,
  input  wire logic       external_count_input,
  input  wire logic       irq_overflow_ack,
  input  wire logic       irq_compare_ack,
  output var  logic       irq_overflow,
  output var  logic       irq_compare,
  output var  logic       compare_output_pin,
  output var  logic       compare_output_en
);

  // ==========================================================
  // register state
  logic [1:0] mode_ff;
  logic [1:0] com_ff;
  logic [2:0] clock_source_select_ff;
  logic [7:0] count_value_ff;
  logic [7:0] cmp_buf_ff;
  logic [7:0] cmp_act_ff;
  logic       overflow_flag_ff;
  logic       compare_match_flag_ff;
  logic       ovf_mask_ff;
  logic       cmp_mask_ff;
  logic       dir_down_ff;
  logic       block_ff;
  logic       oc_ff;
  logic       oc_en_ff;
  logic       irq_ovf_ff;
  logic       irq_cmp_ff;
  logic [7:0] rd_data_ff;
  logic       sel_tick;

  // ==========================================================
  // address decode
  wire logic wr_ctrl  = wr_en && (addr == tmr_pkg::REG_CTRL);
  wire logic wr_cs    = wr_en && (addr == tmr_pkg::REG_CLKSEL);
  wire logic wr_count = wr_en && (addr == tmr_pkg::REG_COUNT);
  wire logic wr_cmp   = wr_en && (addr == tmr_pkg::REG_COMPARE);
  wire logic wr_flag  = wr_en && (addr == tmr_pkg::REG_FLAG);
  wire logic wr_mask  = wr_en && (addr == tmr_pkg::REG_MASK);

  // ==========================================================
  // clock selection
  // stop when unselected
  tmr_clk_sel #(
    .PRESC_W (tmr_pkg::PRESC_W)
  ) u_clk_sel (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .clock_source_select  (clock_source_select_ff),
    .external_count_input (external_count_input),
    .timer_tick           (sel_tick)
  );

  wire logic timer_tick = sel_tick && (clock_source_select_ff != tmr_pkg::CS_STOP);

  // ==========================================================
  // sequence decode
  wire logic is_pwm    = (mode_ff == tmr_pkg::MODE_FAST) || (mode_ff == tmr_pkg::MODE_PHASE);
  wire logic is_phase  = (mode_ff == tmr_pkg::MODE_PHASE);
  // double buffer only in pwm modes
  wire logic [7:0] cmp_eff = is_pwm ? cmp_act_ff : cmp_buf_ff;
  wire logic [7:0] top_val = (mode_ff == tmr_pkg::MODE_CTC) ? cmp_eff : tmr_pkg::CNT_MAX;
  wire logic at_bottom = (count_value_ff == tmr_pkg::CNT_BOTTOM);
  wire logic at_max    = (count_value_ff == tmr_pkg::CNT_MAX);
  wire logic at_top    = (count_value_ff == top_val);
  wire logic match     = (count_value_ff == cmp_eff);
  wire logic match_ev  = timer_tick && match && !block_ff;
  wire logic ovf_ev    = timer_tick && (is_phase ? (dir_down_ff && at_bottom) : at_max);
  wire logic force_ev  = wr_ctrl && wr_data[tmr_pkg::CTRL_FORCE] && !is_pwm;

  // ==========================================================
  // counter next value
  logic [7:0] nxt_count_value;
  logic       nxt_dir_down;

  always_comb
  begin
    nxt_count_value = count_value_ff;
    nxt_dir_down    = dir_down_ff;
    if (timer_tick)
    begin
      if (is_phase)
      begin
        if (!dir_down_ff && at_top)
        begin
          nxt_count_value = count_value_ff - 8'h01;
          nxt_dir_down    = 1'b1;
        end
        else if (dir_down_ff && at_bottom)
        begin
          nxt_count_value = count_value_ff + 8'h01;
          nxt_dir_down    = 1'b0;
        end
        else if (dir_down_ff)
          nxt_count_value = count_value_ff - 8'h01;
        else
          nxt_count_value = count_value_ff + 8'h01;
      end
      else if (at_top)
        nxt_count_value = tmr_pkg::CNT_BOTTOM;
      else
        nxt_count_value = count_value_ff + 8'h01;
    end
    if (wr_count)
      nxt_count_value = wr_data;
  end

  // ==========================================================
  // waveform generator
  logic nxt_oc;

  always_comb
  begin
    nxt_oc = oc_ff;
    if (!is_pwm)
    begin
      if (match_ev || force_ev)
      begin
        unique case (com_ff)
          tmr_pkg::COM_NONE:   nxt_oc = oc_ff;
          tmr_pkg::COM_TOGGLE: nxt_oc = ~oc_ff;
          tmr_pkg::COM_CLEAR:  nxt_oc = 1'b0;
          tmr_pkg::COM_SET:    nxt_oc = 1'b1;
        endcase
      end
    end
    else if (is_phase)
    begin
      if (match_ev && com_ff[1])
        nxt_oc = com_ff[0] ^ dir_down_ff;
    end
    else if (com_ff[1])
    begin
      if (match_ev)
        nxt_oc = com_ff[0];
      else if (timer_tick && at_max)
        nxt_oc = ~com_ff[0];
    end
  end

  // ==========================================================
  // flags
  // compare flag set
  wire logic nxt_cmp_flag = match_ev |
    (compare_match_flag_ff & ~irq_compare_ack & ~(wr_flag & wr_data[tmr_pkg::FLAG_CMP]));
  wire logic nxt_ovf_flag = ovf_ev |
    (overflow_flag_ff & ~irq_overflow_ack & ~(wr_flag & wr_data[tmr_pkg::FLAG_OVF]));

  // ==========================================================
  // read mux
  logic [7:0] rd_mux;

  always_comb
  begin
    rd_mux = 8'h00;
    unique case (addr)
      tmr_pkg::REG_CTRL:    rd_mux = {2'h0, com_ff, 2'h0, mode_ff};
      tmr_pkg::REG_CLKSEL:  rd_mux = {5'h00, clock_source_select_ff};
      tmr_pkg::REG_COUNT:   rd_mux = count_value_ff;
      tmr_pkg::REG_COMPARE: rd_mux = cmp_buf_ff;
      tmr_pkg::REG_FLAG:    rd_mux = {6'h00, compare_match_flag_ff, overflow_flag_ff};
      tmr_pkg::REG_MASK:    rd_mux = {6'h00, cmp_mask_ff, ovf_mask_ff};
      default:              rd_mux = 8'h00;
    endcase
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode_ff                <= tmr_pkg::MODE_RST;
      com_ff                 <= tmr_pkg::COM_RST;
      clock_source_select_ff <= tmr_pkg::CS_RST;
      ovf_mask_ff            <= 1'b0;
      cmp_mask_ff            <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        mode_ff <= wr_data[tmr_pkg::CTRL_MODE_LSB +: 2];
        com_ff  <= wr_data[tmr_pkg::CTRL_COM_LSB +: 2];
      end
      if (wr_cs)
        clock_source_select_ff <= wr_data[2:0];
      if (wr_mask)
      begin
        ovf_mask_ff <= wr_data[tmr_pkg::FLAG_OVF];
        cmp_mask_ff <= wr_data[tmr_pkg::FLAG_CMP];
      end
    end
  end

  // ==========================================================
  // counter and compare registers
  // 8-bit count and compare registers, 1-bit direction and match-block bits
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      count_value_ff <= tmr_pkg::COUNT_RST;
      dir_down_ff    <= 1'b0;
      cmp_buf_ff     <= tmr_pkg::CMP_RST;
      cmp_act_ff     <= tmr_pkg::CMP_RST;
      block_ff       <= 1'b0;
    end
    else
    begin
      count_value_ff <= nxt_count_value;
      dir_down_ff    <= is_phase ? nxt_dir_down : 1'b0;
      if (wr_cmp)
        cmp_buf_ff <= wr_data;
      if (!is_pwm || (timer_tick && at_top))
        cmp_act_ff <= cmp_buf_ff;
      // count write masks next match
      if (wr_count)
        block_ff <= 1'b1;
      else if (timer_tick)
        block_ff <= 1'b0;
    end
  end

  // ==========================================================
  // flags, interrupts, output and read data
  // two sources
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      overflow_flag_ff      <= 1'b0;
      compare_match_flag_ff <= 1'b0;
      irq_ovf_ff            <= 1'b0;
      irq_cmp_ff            <= 1'b0;
      oc_ff                 <= 1'b0;
      oc_en_ff              <= 1'b0;
      rd_data_ff            <= 8'h00;
    end
    else
    begin
      overflow_flag_ff      <= nxt_ovf_flag;
      compare_match_flag_ff <= nxt_cmp_flag;
      irq_ovf_ff            <= nxt_ovf_flag & ovf_mask_ff;
      irq_cmp_ff            <= nxt_cmp_flag & cmp_mask_ff;
      oc_ff                 <= nxt_oc;
      oc_en_ff              <= (com_ff != tmr_pkg::COM_NONE);
      rd_data_ff            <= rd_en ? rd_mux : 8'h00;
    end
  end

  assign rd_data            = rd_data_ff;
  assign irq_overflow       = irq_ovf_ff;
  assign irq_compare        = irq_cmp_ff;
  assign compare_output_pin = oc_ff;
  assign compare_output_en  = oc_en_ff;

endmodule : tmr_timer8

`default_nettype wire

//--- tb/test_tmr_timer8.sv
// self-checking bench for the 8-bit timer
`timescale 1ns/1ps
`default_nettype none
module test_tmr_timer8;
  logic       clk, sys_rst, wr_en, rd_en, ext_in, ack_ovf, ack_cmp;
  logic       irq_overflow, irq_compare, compare_output_pin, compare_output_en;
  logic [2:0] addr;
  logic [7:0] wr_data, rd_data, v;
  int         miscompares, checks, cycles, n;
  int         div_n [5] = '{1, 8, 64, 256, 1024};

  tmr_timer8 tmr_timer8_i (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .external_count_input(ext_in), .irq_overflow_ack(ack_ovf),
    .irq_compare_ack(ack_cmp), .irq_overflow(irq_overflow),
    .irq_compare(irq_compare), .compare_output_pin(compare_output_pin),
    .compare_output_en(compare_output_en)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      test_done();
    end
  end

  // ==========================================================
  // tasks
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic ok(input logic c);
    chk({7'h00, c}, 8'h01);
  endtask : ok
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    v = rd_data;
  endtask : rd
  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    rd(a);
    chk(v, exp);
  endtask : rdchk
  task automatic setup(input logic [7:0] ctrl, cnt, cmp, input logic [2:0] cs);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h00);
    wr(3'h3, cmp);
    wr(3'h2, cnt);
    wr(3'h4, 8'h03);
    wr(3'h0, ctrl);
    wr(3'h1, {5'h00, cs});
  endtask : setup
  task automatic wait_flag(input int b);
    v = 8'h00;
    for (int k = 0; k < 200 && v[b] !== 1'b1; k++)
      rd(3'h4);
  endtask : wait_flag
  task automatic pulses(input int p);
    repeat (p)
    begin
      @(posedge clk);
      ext_in <= 1'b1;
      repeat (8) @(posedge clk);
      ext_in <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask : pulses
  task automatic duty(input logic [7:0] ctrl, input int win, lo, hi);
    int h;
    h = 0;
    setup(ctrl, 8'h00, 8'h40, 3'h1);
    repeat (520) @(posedge clk);
    repeat (win)
    begin
      @(negedge clk);
      h += compare_output_pin;
    end
    ok(h >= lo && h <= hi);
  endtask : duty

  // ==========================================================
  // main sequence
  initial
  begin
    {sys_rst, wr_en, rd_en, ext_in, ack_ovf, ack_cmp} = 6'h20;
    addr = 3'h0;
    wr_data = 8'h00;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    for (n = 0; n < 8; n++)
      rdchk(n[2:0], 8'h00);
    wr(3'h1, 8'h07);
    rdchk(3'h1, 8'h07);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h5a);
    repeat (20) @(posedge clk);
    rdchk(3'h2, 8'h5a);
    wr(3'h3, 8'ha5);
    rdchk(3'h3, 8'ha5);
    wr(3'h5, 8'h03);
    rdchk(3'h5, 8'h03);
    setup(8'h00, 8'hfc, 8'h00, 3'h1);
    wait_flag(0);
    ok(irq_overflow);
    wr(3'h1, 8'h00);
    rd(3'h2);
    ok(v < 8'h10);
    ok(!compare_output_en);
    @(posedge clk);
    ack_ovf <= 1'b1;
    @(posedge clk);
    ack_ovf <= 1'b0;
    rd(3'h4);
    ok(!v[0] && !irq_overflow);
    setup(8'h00, 8'h10, 8'h30, 3'h1);
    wait_flag(1);
    ok(irq_compare);
    wr(3'h1, 8'h00);
    rd(3'h2);
    ok(v > 8'h30 && v < 8'h3c);
    wr(3'h4, 8'h02);
    rd(3'h4);
    ok(!v[1] && !irq_compare);
    wr(3'h5, 8'h01);
    setup(8'h00, 8'h10, 8'h30, 3'h1);
    wait_flag(1);
    ok(v[1] && !irq_compare);
    @(posedge clk);
    ack_cmp <= 1'b1;
    @(posedge clk);
    ack_cmp <= 1'b0;
    rd(3'h4);
    ok(!v[1]);
    setup(8'h02, 8'h00, 8'h05, 3'h1);
    for (n = 0; n < 12; n++)
    begin
      rd(3'h2);
      ok(v <= 8'h05);
    end
    rd(3'h4);
    ok(v[1] && !v[0]);
    for (n = 0; n < 5; n++)
    begin
      setup(8'h00, 8'h00, 8'hff, n[2:0] + 3'h1);
      repeat (8 * div_n[n]) @(posedge clk);
      wr(3'h1, 8'h00);
      rd(3'h2);
      ok(v >= 8'h07 && v <= 8'h0b);
    end
    setup(8'h00, 8'h00, 8'hff, 3'h7);
    pulses(3);
    rdchk(3'h2, 8'h03);
    wr(3'h1, 8'h06);
    pulses(2);
    rdchk(3'h2, 8'h05);
    setup(8'h00, 8'h00, 8'hff, 3'h1);
    wr(3'h2, 8'h80);
    rd(3'h2);
    ok(v >= 8'h80 && v <= 8'h83);
    setup(8'h10, 8'h00, 8'h08, 3'h1);
    repeat (20) @(posedge clk);
    ok(compare_output_en && compare_output_pin);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h90);
    repeat (3) @(posedge clk);
    ok(!compare_output_pin);
    duty(8'h23, 512, 122, 138);
    duty(8'h21, 1020, 246, 266);
    test_done();
  end
endmodule : test_tmr_timer8

bind tmr_timer8 tmr_timer8_asserts tmr_timer8_asserts_i (
  .clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .irq_overflow_ack(irq_overflow_ack), .irq_compare_ack(irq_compare_ack),
  .irq_overflow(irq_overflow), .irq_compare(irq_compare),
  .compare_output_en(compare_output_en)
);
`default_nettype wire

//--- tb/tmr_timer8_asserts.sv
// port-level assertion checker for the 8-bit timer
`timescale 1ns/1ps
`default_nettype none
module tmr_timer8_asserts (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rd_data,
  input wire logic       irq_overflow_ack,
  input wire logic       irq_compare_ack,
  input wire logic       irq_overflow,
  input wire logic       irq_compare,
  input wire logic       compare_output_en
);
  // ==========================================================
  // helper decode
  wire logic ctrl_wr = wr_en && addr == tmr_pkg::REG_CTRL;
  wire logic flag_wr = wr_en && addr == tmr_pkg::REG_FLAG;
  wire logic mask_wr = wr_en && addr == tmr_pkg::REG_MASK;
  wire logic sel_wr  = wr_en && addr == tmr_pkg::REG_CLKSEL;
  wire logic sel_rd  = rd_en && addr == tmr_pkg::REG_CLKSEL;
  wire logic clr_wr  = flag_wr || mask_wr;
  logic [1:0] mask_ff;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mask_ff <= 2'h0;
    else if (mask_wr)
      mask_ff <= wr_data[1:0];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // properties
  property p_rd_idle;
    !$past(rd_en) |-> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmapped;
    rd_en && addr > tmr_pkg::REG_MASK |=> rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_force_rd;
    rd_en && addr == tmr_pkg::REG_CTRL |=> !rd_data[7];
  endproperty
  a_force_rd: assert property (p_force_rd) else $error("force bit reads one");
  property p_sel_back;
    sel_wr ##2 sel_rd |=> rd_data[2:0] == $past(wr_data[2:0], 3);
  endproperty
  a_sel_back: assert property (p_sel_back) else $error("clock select lost");
  property p_ovf_clear;
    $fell(irq_overflow) |-> $past(irq_overflow_ack) || $past(clr_wr) || $past(mask_wr, 2);
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow irq dropped");
  property p_cmp_clear;
    $fell(irq_compare) |-> $past(irq_compare_ack) || $past(clr_wr) || $past(mask_wr, 2);
  endproperty
  a_cmp_clear: assert property (p_cmp_clear) else $error("compare irq dropped");
  property p_oe_cause;
    $changed(compare_output_en) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("output enable moved");
  property p_ovf_mask;
    irq_overflow |-> mask_ff[0] || $past(mask_ff[0]);
  endproperty
  a_ovf_mask: assert property (p_ovf_mask) else $error("masked irq raised");
  property p_cmp_mask;
    irq_compare |-> mask_ff[1] || $past(mask_ff[1]);
  endproperty
  a_cmp_mask: assert property (p_cmp_mask) else $error("masked compare irq raised");
endmodule : tmr_timer8_asserts
`default_nettype wire
